// ==== fesm_line_model.sv ====
/* Remote line terminal: frames, timeslot 16, Sa message bits.
   Assumes go_i pulses once per frame. */
`default_nettype none
module fesm_line_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic go_i, // Emit one frame
  input wire logic clr_i, // Restart frame count
  input wire logic mf_en_i, // Send multiframe syncs
  input wire logic [7:0] ts16_i, // Timeslot 16 content
  input wire logic [3:0] code_i, // Message to send
  input wire logic [2:0] sel_i, // Sa position
  input wire logic ssm_bit_i, // Device message bit
  output logic frame_o, // Frame start
  output logic mf_o, // Multiframe sync
  output logic [7:0] ts16_o, // Timeslot 16
  output logic [4:0] sa_o, // Sa4..Sa8
  output logic [3:0] ssm_word_o // Last message bits
);
  logic [3:0] cnt_r;
  logic take_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
      take_r <= 1'b0;
      frame_o <= 1'b0;
      mf_o <= 1'b0;
      ts16_o <= 8'h00;
      sa_o <= 5'h00;
      ssm_word_o <= 4'h0;
    end else begin
      frame_o <= go_i;
      mf_o <= go_i && mf_en_i && cnt_r == 4'h0;
      // Off-frame data toggles so stale values never look valid
      ts16_o <= go_i ? ts16_i : ~ts16_o;
      sa_o <= ~sa_o;
      if (go_i && cnt_r[0]) begin
        sa_o[sel_i] <= code_i[2'h3 - cnt_r[2:1]];
      end
      if (go_i) begin
        cnt_r <= cnt_r + 4'h1;
      end
      if (clr_i) begin
        cnt_r <= 4'h0;
      end
      take_r <= frame_o && !cnt_r[0];
      if (take_r) begin
        ssm_word_o <= {ssm_word_o[2:0], ssm_bit_i};
      end
    end
  end
endmodule : fesm_line_model
`default_nettype wire

// ==== fesm_monitor.sv ====
/* Port checker for fesm_top.
   Assumes its ports are tied to the top. */
`default_nettype none
module fesm_monitor (
  input wire logic ref_clk_i, // Clock
  input wire logic reset_n_i, // Reset
  input wire logic [fesm_pkg::ADDR_W-1:0] avs_address_i, // Address
  input wire logic avs_read_i, // Read
  input wire logic avs_write_i, // Write
  input wire logic [fesm_pkg::DATA_W-1:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic rx_frame_i, // Rx frame
  input wire logic tx_frame_i, // Tx frame
  input wire logic rx_fdl_vld_i, // Link bit strobe
  input wire logic rx_link_full_i, // Link full
  input wire logic tx_clock_loss_i, // Clock loss
  input wire logic rx_alarm_ci_i, // Alarm
  input wire logic tx_fdl_req_i, // Link bit wanted
  input wire logic tx_fdl_bit_o, // Link bit out
  input wire logic tx_ssm_bit_o, // Message bit
  input wire logic [2:0] tx_ssm_sel_o, // Sa position
  input wire logic irq_o // Interrupt
);
  import fesm_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ********
  // Bus, interrupt and output hold relations
  // ********
  property p_wait_one;
    $rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest not one cycle");
  property p_idle;
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("waitrequest without request");
  property p_bit7;
    avs_read_i && !avs_waitrequest_o && avs_address_i[8:3] == 6'h0D
      |-> avs_readdata_o[31:7] == '0;
  endproperty
  a_bit7: assert property (p_bit7)
    else $error("frame register top bits not zero");
  property p_irq_rise;
    $rose(irq_o) |-> $past(avs_write_i || rx_frame_i || tx_frame_i ||
      rx_fdl_vld_i || rx_link_full_i || tx_clock_loss_i || rx_alarm_ci_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(irq_o) |-> $past(avs_read_i || avs_write_i, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without access");
  property p_fdl_hold;
    !$past(tx_fdl_req_i) |-> $stable(tx_fdl_bit_o);
  endproperty
  a_fdl_hold: assert property (p_fdl_hold)
    else $error("link bit moved without request");
  property p_ssm_hold;
    !$past(tx_frame_i) |-> $stable(tx_ssm_bit_o);
  endproperty
  a_ssm_hold: assert property (p_ssm_hold)
    else $error("message bit moved without frame");
  property p_sel_hold;
    !$past(avs_write_i) |-> $stable(tx_ssm_sel_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("Sa position moved without write");
endmodule : fesm_monitor
bind fesm_top fesm_monitor u_mon (.*);
`default_nettype wire

// ==== fesm_pkg.sv ====
/*
 * Shared constants for the frame event status and sync message block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses; each register
 * takes one aligned word at four times its index.
 */
`default_nettype none
package fesm_pkg;
  // ***********************************************************
  // Register indexes and bus layout
  // ***********************************************************
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam logic [6:0] IDX_LINK_STAT = 7'h18;
  localparam logic [6:0] IDX_LINK_MASK = 7'h19;
  localparam logic [6:0] IDX_FRAME_STAT = 7'h1A;
  localparam logic [6:0] IDX_FRAME_MASK = 7'h1B;
  localparam logic [6:0] IDX_TX_LINK_BYTE = 7'h51;
  localparam logic [6:0] IDX_CTRL = 7'h60;
  localparam logic [6:0] IDX_SSM_TX = 7'h61;
  localparam logic [6:0] IDX_SSM_RX = 7'h62;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] FRAME_MASK_USED = 8'h7F;
  localparam logic [7:0] LINK_MASK_USED = 8'hF8;
  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int unsigned FB_RX_ALIGN = 0;
  localparam int unsigned FB_RX_CRC_MF = 1;
  localparam int unsigned FB_RX_MF = 2;
  localparam int unsigned FB_TX_ALIGN = 3;
  localparam int unsigned FB_TX_MF = 4;
  localparam int unsigned FB_SIG_ZEROS = 5;
  localparam int unsigned FB_SIG_ONES = 6;
  localparam int unsigned LB_LINK_FULL = 3;
  localparam int unsigned LB_LINK_ABORT = 4;
  localparam int unsigned LB_CODE_CLEAR = 5;
  localparam int unsigned LB_CLOCK_LOSS = 6;
  localparam int unsigned LB_ALARM_CI = 7;
  localparam int unsigned CB_E1 = 0;
  localparam int unsigned CB_ESF = 1;
  localparam int unsigned CB_CRC4 = 2;
  localparam int unsigned CB_SA_LO = 3;
  localparam int unsigned SB_VALID = 4;
  localparam int unsigned SB_RESERVED = 5;
  // ***********************************************************
  // Frame counts
  // ***********************************************************
  localparam logic [4:0] LAST_E1 = 5'h0F;
  localparam logic [4:0] LAST_D4 = 5'h0B;
  localparam logic [4:0] LAST_ESF = 5'h17;
  localparam logic [3:0] LAST_CRC = 4'hF;
  localparam logic [3:0] ONES_ABORT = 4'h8;
  localparam logic [4:0] CLEAR_BITS = 5'h1E;
  localparam logic [7:0] ONES_MAX_ZEROS = 8'h03;
  localparam logic [1:0] SSM_ALIKE = 2'h2;
  // ***********************************************************
  // Quality level codes
  // ***********************************************************
  typedef enum logic [3:0] {
    FESM_QL_UNKNOWN = 4'b0000,
    FESM_QL_PRC = 4'b0010,
    FESM_QL_SSU_A = 4'b0100,
    FESM_QL_SSU_B = 4'b1000,
    FESM_QL_SEC = 4'b1011,
    FESM_QL_DNU = 4'b1111
  } fesm_ql_e;
endpackage : fesm_pkg
`default_nettype wire

// ==== fesm_top.sv ====
/*
 * Frame and multiframe event status, link event masks, transmit link
 * byte serialiser and E1 sync status message handling.
 * Assumes frame pulses and line data come from framer logic on the
 * same clock, one pulse per frame, data valid in the pulse cycle.
 */
// Overview of operation
// - Mask bits 3-7 gate link events
// - E1 receive align event each align frame
// - E1 CRC multiframe event, free-running without CRC4
// - E1 receive multiframe event every multiframe
// - T1 multiframe events on D4/ESF boundaries
// - E1 transmit align event each align frame
// - E1 transmit multiframe event every multiframe
// - Timeslot 16 all zeros over multiframe
// - Timeslot 16 under three zeros, 16 frames
// - Mask bits 0-6 gate frame events
// - Link byte sent LSB first, bytewise
// - D4 Fs pattern taken from link byte
// - Host reads and writes sync Sa data
// - Message rides one chosen Sa4-Sa8 bit
// - Message MSB first, two per multiframe
// - Valid after three alike sub-multiframes
// - Four-bit quality codes, rest reserved
// - Eight ones on link raise abort
// - Thirty bits without abort raise clear
`default_nettype none
module fesm_top (
  input wire logic ref_clk_i, // Core clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic [fesm_pkg::ADDR_W-1:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [fesm_pkg::DATA_W-1:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  output logic [fesm_pkg::DATA_W-1:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic rx_frame_i, // Receive frame start
  input wire logic rx_mf_i, // Receive multiframe sync
  input wire logic rx_crc_mf_i, // Receive CRC4 multiframe sync
  input wire logic [7:0] rx_ts16_i, // Timeslot 16 byte
  input wire logic [4:0] rx_sa_i, // Received Sa4..Sa8
  input wire logic rx_fdl_vld_i, // Receive link bit strobe
  input wire logic rx_fdl_bit_i, // Receive link bit
  input wire logic rx_link_full_i, // Receive link buffer full
  input wire logic tx_clock_loss_i, // Transmit clock lost
  input wire logic rx_alarm_ci_i, // AIS-CI seen
  input wire logic tx_frame_i, // Transmit frame start
  input wire logic tx_fdl_req_i, // Next link bit wanted
  output logic tx_fdl_bit_o, // Transmit link bit
  output logic tx_ssm_bit_o, // Transmit message bit
  output logic [2:0] tx_ssm_sel_o, // Sa position, 0 is Sa4
  output logic irq_o // Interrupt request
);
  import fesm_pkg::*;

  // ***********************************************************
  // Decoding helpers
  // ***********************************************************
  function automatic logic [4:0] mf_last(input logic e1,
                                         input logic esf);
    if (e1) begin
      return LAST_E1;
    end else if (esf) begin
      return LAST_ESF;
    end
    return LAST_D4;
  endfunction : mf_last

  function automatic logic [3:0] zero_count(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, ~b[i]};
    end
    return n;
  endfunction : zero_count

  function automatic logic sa_pick(input logic [4:0] sa,
                                   input logic [2:0] sel);
    if (sel > 3'd4) begin
      return sa[0];
    end
    return sa[sel];
  endfunction : sa_pick

  function automatic logic code_reserved(input logic [3:0] c);
    case (c)
      FESM_QL_UNKNOWN, FESM_QL_PRC, FESM_QL_SSU_A,
      FESM_QL_SSU_B, FESM_QL_SEC, FESM_QL_DNU: begin
        return 1'b0;
      end
      default: begin
        return 1'b1;
      end
    endcase
  endfunction : code_reserved

  // ***********************************************************
  // Register bus
  // ***********************************************************
  logic ack_r;
  logic req;
  logic wr_acc;
  logic rd_acc;
  logic [6:0] idx;
  logic [7:0] frame_stat_r;
  logic [7:0] frame_mask_r;
  logic [7:0] link_stat_r;
  logic [7:0] link_mask_r;
  logic [7:0] tx_byte_r;
  logic [7:0] ctrl_r;
  logic [3:0] ssm_tx_r;
  logic [3:0] ssm_rx_r;
  logic ssm_valid_r;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] frame_set;
  logic [7:0] link_set;
  logic e1;
  logic [2:0] sa_sel;

  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[8:2];
  assign wbyte = avs_writedata_i[7:0];
  // One stall cycle gives a registered read answer
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_acc = avs_write_i & ack_r & avs_byteenable_i[0];
  assign rd_acc = avs_read_i & ack_r;
  assign e1 = ctrl_r[CB_E1];
  assign sa_sel = ctrl_r[CB_SA_LO +: 3];

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_LINK_STAT: rd_byte = link_stat_r;
      IDX_LINK_MASK: rd_byte = link_mask_r;
      IDX_FRAME_STAT: rd_byte = frame_stat_r;
      IDX_FRAME_MASK: rd_byte = frame_mask_r;
      IDX_TX_LINK_BYTE: rd_byte = tx_byte_r;
      IDX_CTRL: rd_byte = ctrl_r;
      IDX_SSM_TX: rd_byte = {4'h0, ssm_tx_r};
      IDX_SSM_RX: begin
        rd_byte = {2'b00, code_reserved(ssm_rx_r), ssm_valid_r,
                   ssm_rx_r};
      end
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_mask_r <= RST_BYTE;
      link_mask_r <= RST_BYTE;
      tx_byte_r <= RST_BYTE;
      ctrl_r <= RST_BYTE;
      ssm_tx_r <= 4'h0;
    end else if (wr_acc) begin
      case (idx)
        // Bit 7 is not stored, so a stray one cannot unmask anything
        IDX_FRAME_MASK: frame_mask_r <= wbyte & FRAME_MASK_USED;
        IDX_LINK_MASK: link_mask_r <= wbyte & LINK_MASK_USED;
        IDX_TX_LINK_BYTE: tx_byte_r <= wbyte;
        IDX_CTRL: ctrl_r <= {2'b00, wbyte[5:0]};
        IDX_SSM_TX: ssm_tx_r <= wbyte[3:0];
        default: ;
      endcase
    end
  end

  // Clear on read; an event in the clearing cycle still lands
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_stat_r <= RST_BYTE;
    end else if (rd_acc && idx == IDX_FRAME_STAT) begin
      frame_stat_r <= frame_set;
    end else begin
      frame_stat_r <= frame_stat_r | frame_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_stat_r <= RST_BYTE;
    end else if (rd_acc && idx == IDX_LINK_STAT) begin
      link_stat_r <= link_set;
    end else begin
      link_stat_r <= link_stat_r | link_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(frame_stat_r & frame_mask_r)
             | |(link_stat_r & link_mask_r);
    end
  end

  // ***********************************************************
  // Receive frame counting
  // ***********************************************************
  logic [4:0] rx_cnt_r;
  logic [4:0] rx_cnt_nxt;
  logic [3:0] crc_cnt_r;
  logic [3:0] crc_cnt_nxt;
  logic rx_mf_hit;
  logic crc_mf_hit;
  logic crc_sync;

  assign rx_mf_hit = rx_frame_i &
                     (rx_mf_i | rx_cnt_r == mf_last(e1, ctrl_r[CB_ESF]));
  assign rx_cnt_nxt = rx_mf_hit ? 5'h00 : rx_cnt_r + 5'h01;
  // Without CRC4 the sync pulse is ignored and the count free-runs
  assign crc_sync = ctrl_r[CB_CRC4] & rx_crc_mf_i;
  assign crc_mf_hit = rx_frame_i &
                      (crc_sync | crc_cnt_r == LAST_CRC);
  assign crc_cnt_nxt = crc_mf_hit ? 4'h0 : crc_cnt_r + 4'h1;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_cnt_r <= 5'h00;
      crc_cnt_r <= 4'h0;
    end else if (rx_frame_i) begin
      rx_cnt_r <= rx_cnt_nxt;
      crc_cnt_r <= crc_cnt_nxt;
    end
  end

  // ***********************************************************
  // Transmit frame counting
  // ***********************************************************
  logic [4:0] tx_cnt_r;
  logic [4:0] tx_cnt_nxt;
  logic tx_mf_hit;

  assign tx_mf_hit = tx_frame_i &
                     (tx_cnt_r == mf_last(e1, ctrl_r[CB_ESF]));
  assign tx_cnt_nxt = tx_mf_hit ? 5'h00 : tx_cnt_r + 5'h01;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_cnt_r <= 5'h00;
    end else if (tx_frame_i) begin
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  // ***********************************************************
  // Timeslot 16 signalling checks
  // ***********************************************************
  logic [7:0] ts16_or_r;
  logic mf_seen_r;
  logic [3:0] zc_r [16];
  logic [3:0] zptr_r;
  logic [7:0] zsum_r;
  logic [7:0] zsum_nxt;
  logic [4:0] zfill_r;
  logic [3:0] zc;
  logic sig_zeros_hit;
  logic sig_ones_hit;

  assign zc = zero_count(rx_ts16_i);
  assign zsum_nxt = zsum_r - {4'h0, zc_r[zptr_r]} + {4'h0, zc};
  assign sig_zeros_hit = e1 & rx_mf_hit & mf_seen_r &
                         ~|ts16_or_r;
  assign sig_ones_hit = e1 & rx_frame_i & zfill_r >= 5'd15 &
                        zsum_nxt < ONES_MAX_ZEROS;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ts16_or_r <= 8'h00;
      mf_seen_r <= 1'b0;
    end else if (e1 && rx_frame_i) begin
      if (rx_mf_hit) begin
        ts16_or_r <= rx_ts16_i;
        mf_seen_r <= 1'b1;
      end else begin
        ts16_or_r <= ts16_or_r | rx_ts16_i;
      end
    end
  end

  // Sliding sum keeps the check live in every frame, CCS included
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 16; i++) begin
        zc_r[i] <= 4'h0;
      end
      zptr_r <= 4'h0;
      zsum_r <= 8'h00;
      zfill_r <= 5'h00;
    end else if (e1 && rx_frame_i) begin
      zc_r[zptr_r] <= zc;
      zptr_r <= zptr_r + 4'h1;
      zsum_r <= zsum_nxt;
      if (zfill_r != 5'd16) begin
        zfill_r <= zfill_r + 5'h01;
      end
    end
  end

  // ***********************************************************
  // Receive link events
  // ***********************************************************
  logic [3:0] ones_r;
  logic [4:0] since_r;
  logic abort_hit;
  logic clear_hit;

  assign abort_hit = rx_fdl_vld_i & rx_fdl_bit_i &
                     ones_r == ONES_ABORT - 4'h1;
  assign clear_hit = rx_fdl_vld_i & ~abort_hit &
                     since_r == CLEAR_BITS - 5'h01;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ones_r <= 4'h0;
    end else if (rx_fdl_vld_i) begin
      if (!rx_fdl_bit_i) begin
        ones_r <= 4'h0;
      end else if (ones_r != ONES_ABORT) begin
        ones_r <= ones_r + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      since_r <= 5'h00;
    end else if (abort_hit) begin
      since_r <= 5'h00;
    end else if (rx_fdl_vld_i && since_r != CLEAR_BITS) begin
      since_r <= since_r + 5'h01;
    end
  end

  // ***********************************************************
  // Event sources
  // ***********************************************************
  always_comb begin
    frame_set = 8'h00;
    frame_set[FB_RX_ALIGN] = e1 & rx_frame_i &
                             ~crc_cnt_nxt[0];
    frame_set[FB_RX_CRC_MF] = e1 & crc_mf_hit;
    frame_set[FB_RX_MF] = rx_mf_hit;
    frame_set[FB_TX_ALIGN] = e1 & tx_frame_i &
                             ~tx_cnt_nxt[0];
    frame_set[FB_TX_MF] = tx_mf_hit;
    frame_set[FB_SIG_ZEROS] = sig_zeros_hit;
    frame_set[FB_SIG_ONES] = sig_ones_hit;
  end

  always_comb begin
    link_set = 8'h00;
    link_set[LB_LINK_FULL] = rx_link_full_i;
    link_set[LB_LINK_ABORT] = abort_hit;
    link_set[LB_CODE_CLEAR] = clear_hit;
    link_set[LB_CLOCK_LOSS] = tx_clock_loss_i;
    link_set[LB_ALARM_CI] = rx_alarm_ci_i;
  end

  // ***********************************************************
  // Transmit link byte serialiser
  // ***********************************************************
  logic [2:0] tx_bit_idx_r;
  logic [7:0] tx_sh_r;

  // Byte is sampled at bit 0 so a mid-byte write cannot tear it;
  // in D4 the same stream supplies the Fs pattern bits
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_bit_idx_r <= 3'h0;
      tx_sh_r <= RST_BYTE;
      tx_fdl_bit_o <= 1'b0;
    end else if (tx_fdl_req_i) begin
      tx_bit_idx_r <= tx_bit_idx_r + 3'h1;
      if (tx_bit_idx_r == 3'h0) begin
        tx_sh_r <= tx_byte_r;
        tx_fdl_bit_o <= tx_byte_r[0];
      end else begin
        tx_fdl_bit_o <= tx_sh_r[tx_bit_idx_r];
      end
    end
  end

  // ***********************************************************
  // Sync status message
  // ***********************************************************
  logic [2:0] rx_sh_r;
  logic [3:0] ssm_last_r;
  logic [1:0] ssm_alike_r;
  logic [3:0] ssm_word;
  logic sa_bit;
  logic sa_frame;

  assign sa_bit = sa_pick(rx_sa_i, sa_sel);
  assign ssm_word = {rx_sh_r, sa_bit};
  // Sa bits only ride non-align (odd) frames
  assign sa_frame = e1 & rx_frame_i & crc_cnt_nxt[0];
  assign tx_ssm_sel_o = sa_sel;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sh_r <= 3'h0;
      ssm_last_r <= 4'h0;
      ssm_alike_r <= 2'h0;
      ssm_rx_r <= 4'h0;
      ssm_valid_r <= 1'b0;
    end else if (sa_frame) begin
      rx_sh_r <= ssm_word[2:0];
      if (crc_cnt_nxt[2:0] == 3'h7) begin
        ssm_last_r <= ssm_word;
        if (ssm_word != ssm_last_r) begin
          ssm_alike_r <= 2'h0;
        end else if (ssm_alike_r != SSM_ALIKE) begin
          ssm_alike_r <= ssm_alike_r + 2'h1;
        end
        if (ssm_word == ssm_last_r &&
            ssm_alike_r >= SSM_ALIKE - 2'h1) begin
          ssm_rx_r <= ssm_word;
          ssm_valid_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_ssm_bit_o <= 1'b0;
    end else if (e1 && tx_frame_i && tx_cnt_nxt[0]) begin
      tx_ssm_bit_o <= ssm_tx_r[2'd3 - tx_cnt_nxt[2:1]];
    end
  end
endmodule : fesm_top
`default_nettype wire

// ==== tb_fesm_top.sv ====
/* Self-checking bench for fesm_top.
   Assumes fesm_line_model on the line side, bench as host. */
`default_nettype none
module tb_fesm_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fesm_pkg::*;
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end
  logic ref_clk_i, reset_n_i, read, write, waitreq, irq, go, clr, mf_en;
  logic frame, mf, fdl_vld, fdl_bit, full, loss, ais, fdl_req, fdl_out;
  logic ssm_out;
  logic [8:0] address;
  logic [31:0] wdata, rdata;
  logic [3:0] byteen, code, ssm_word;
  logic [7:0] ts16, ts16_in, junk;
  logic [4:0] sa;
  logic [2:0] ssm_sel;
  int fails, cmp_count;
  fesm_top DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
    .avs_writedata_i(wdata), .avs_byteenable_i(byteen),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .rx_frame_i(frame), .rx_mf_i(mf), .rx_crc_mf_i(mf), .rx_ts16_i(ts16),
    .rx_sa_i(sa), .rx_fdl_vld_i(fdl_vld), .rx_fdl_bit_i(fdl_bit),
    .rx_link_full_i(full), .tx_clock_loss_i(loss), .rx_alarm_ci_i(ais),
    .tx_frame_i(frame), .tx_fdl_req_i(fdl_req), .tx_fdl_bit_o(fdl_out),
    .tx_ssm_bit_o(ssm_out), .tx_ssm_sel_o(ssm_sel), .irq_o(irq));
  fesm_line_model u_line (.clk_i(ref_clk_i), .rst_n_i(reset_n_i),
    .go_i(go), .clr_i(clr), .mf_en_i(mf_en), .ts16_i(ts16_in),
    .code_i(code), .sel_i(3'h1), .ssm_bit_i(ssm_out), .frame_o(frame),
    .mf_o(mf), .ts16_o(ts16), .sa_o(sa), .ssm_word_o(ssm_word));
  // ********
  // Bus and stimulus tasks
  // ********
  task automatic bus(input logic w, input logic [6:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk_i);
    address <= {idx, 2'h0};
    read <= !w;
    write <= w;
    wdata <= {24'h00_0000, wd};
    do @(posedge ref_clk_i); while (waitreq !== 1'b0);
    rd = rdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, junk);
  endtask : wr
  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e,
      input logic [7:0] m, input string nm);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    `CHK(nm, e, d & m)
  endtask : rd_chk
  task automatic frames(input int n);
    repeat (n) begin
      @(posedge ref_clk_i) go <= 1'b1;
      @(posedge ref_clk_i) go <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask : frames
  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(posedge ref_clk_i) fdl_vld <= 1'b1;
      fdl_bit <= b;
      @(posedge ref_clk_i) fdl_vld <= 1'b0;
    end
  endtask : bits
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rd_chk(IDX_FRAME_STAT, RST_BYTE, 8'hFF, "status rst");
    rd_chk(IDX_FRAME_MASK, RST_BYTE, 8'hFF, "mask rst");
    rd_chk(IDX_TX_LINK_BYTE, RST_BYTE, 8'hFF, "byte rst");
    rd_chk(7'h00, 8'h00, 8'hFF, "unmapped");
    wr(IDX_FRAME_MASK, FRAME_MASK_USED);
    byteen <= 4'h0;
    wr(IDX_FRAME_MASK, 8'h00);
    byteen <= 4'hF;
    rd_chk(IDX_FRAME_MASK, 8'h7F, 8'hFF, "frame mask");
    wr(IDX_LINK_MASK, 8'hFF);
    rd_chk(IDX_LINK_MASK, 8'hF8, 8'hFF, "link mask");
    $display("test regs done");
  endtask : t_regs
  task automatic t_txbyte;
    logic [7:0] got;
    wr(IDX_TX_LINK_BYTE, 8'h1D);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk_i) fdl_req <= 1'b1;
      @(posedge ref_clk_i) fdl_req <= 1'b0;
      #1 got[i] = fdl_out;
    end
    `CHK("link bits", 8'h1D, got)
    $display("test tx byte done");
  endtask : t_txbyte
  task automatic t_e1;
    wr(IDX_CTRL, 8'h01);
    ts16_in <= 8'hFF;
    frames(15);
    rd_chk(IDX_FRAME_STAT, 8'h00, 8'h56, "mf early");
    frames(1);
    `CHK("irq set", 1'b1, irq)
    rd_chk(IDX_FRAME_STAT, 8'h56, 8'h56, "mf");
    frames(2);
    rd_chk(IDX_FRAME_STAT, 8'h09, 8'h09, "align");
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq clr", 1'b0, irq)
    ts16_in <= 8'h00;
    wr(IDX_FRAME_MASK, 8'h00);
    frames(14);
    rd_chk(IDX_FRAME_STAT, 8'h00, 8'h20, "zeros early");
    frames(16);
    `CHK("irq masked", 1'b0, irq)
    rd_chk(IDX_FRAME_STAT, 8'h3F, 8'h7F, "zeros");
    $display("test e1 done");
  endtask : t_e1
  task automatic t_t1;
    for (int i = 0; i < 2; i++) begin
      wr(IDX_CTRL, {6'h00, i[0], 1'b0});
      frames(i == 0 ? 11 : 23);
      rd_chk(IDX_FRAME_STAT, 8'h00, 8'h7F, "t1 early");
      frames(1);
      rd_chk(IDX_FRAME_STAT, 8'h14, 8'h7F, "t1 mf");
    end
    $display("test t1 done");
  endtask : t_t1
  task automatic t_link;
    bits(7, 1'b1);
    rd_chk(IDX_LINK_STAT, 8'h00, 8'hF8, "abort early");
    bits(1, 1'b1);
    rd_chk(IDX_LINK_STAT, 8'h10, 8'hF8, "abort");
    bits(29, 1'b0);
    rd_chk(IDX_LINK_STAT, 8'h00, 8'hF8, "clear early");
    bits(1, 1'b0);
    rd_chk(IDX_LINK_STAT, 8'h20, 8'hF8, "clear");
    @(posedge ref_clk_i) {full, loss, ais} <= 3'h7;
    @(posedge ref_clk_i) {full, loss, ais} <= 3'h0;
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq link", 1'b1, irq)
    wr(IDX_LINK_MASK, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq link off", 1'b0, irq)
    rd_chk(IDX_LINK_STAT, 8'hC8, 8'hF8, "link events");
    $display("test link done");
  endtask : t_link
  task automatic t_ssm;
    wr(IDX_CTRL, 8'h0D);
    wr(IDX_SSM_TX, {4'h0, FESM_QL_SEC});
    code <= FESM_QL_PRC;
    mf_en <= 1'b1;
    @(posedge ref_clk_i) clr <= 1'b1;
    @(posedge ref_clk_i) clr <= 1'b0;
    `CHK("sa sel", 3'h1, ssm_sel)
    frames(48);
    rd_chk(IDX_SSM_RX, 8'h12, 8'hFF, "rx msg");
    `CHK("tx msg", FESM_QL_SEC, ssm_word)
    $display("test ssm done");
  endtask : t_ssm
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    tally_and_finish();
  end
  initial begin
    {reset_n_i, read, write, go, clr, mf_en, fdl_req} = 7'h00;
    {fdl_vld, fdl_bit, full, loss, ais} = 5'h00;
    address = 9'h000;
    wdata = 32'h0000_0000;
    byteen = 4'hF;
    ts16_in = 8'h00;
    code = 4'h0;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_txbyte();
    t_e1();
    t_t1();
    t_link();
    t_ssm();
    tally_and_finish();
  end
endmodule : tb_fesm_top
`default_nettype wire
